// File: dv/irtcb_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "irtcb_consts.svh"

// ============
// Port-level checker for the IR control block
// ============
module irtcb_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    // Infrared side
    input wire logic tx_reload,
    input wire logic ir_enable,
    input wire logic rx_mode,
    input wire logic [15:0] modulator_time,
    input wire logic irq
);
    logic ph_q, wr_q, burst_q, en_q;
    logic [7:0] idx_q;
    logic [1:0] mask_q;
    // Transfer decode; reads keep ph_q up through their wait cycle
    wire taken = hsel && hready && (htrans == `IRTCB_HTRANS_NONSEQ);
    wire wr_ph = ph_q && wr_q;
    wire wr_ctl = wr_ph && (idx_q == `IRTCB_IDX_CONTROL_B);
    wire wr_mt = wr_ph && (idx_q == `IRTCB_IDX_MOD_TIME);
    wire burst_rise = wr_ctl && hwdata[`IRTCB_BIT_BURST] && !burst_q;

    // Shadow of the software-owned bits, so flags need no internal probe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= 8'h00;
            burst_q <= 1'b0;
            en_q <= 1'b0;
            mask_q <= 2'h0;
        end else begin
            if (hready) begin
                ph_q <= taken;
                wr_q <= hwrite;
                idx_q <= haddr[9:2];
            end
            if (wr_ctl) begin
                burst_q <= hwdata[`IRTCB_BIT_BURST];
                en_q <= hwdata[`IRTCB_BIT_IRQ_EN];
            end
            if (wr_ph && (idx_q == `IRTCB_IDX_IRQ_MASK)) begin
                mask_q <= hwdata[1:0];
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    // ============
    // Sequences
    // ============
    sequence s_rd_ctl;
        taken && !hwrite && (haddr[9:2] == `IRTCB_IDX_CONTROL_B);
    endsequence
    sequence s_rd_done;
        !hreadyout ##1 hreadyout;
    endsequence
    sequence s_reload;
        en_q && ir_enable && !rx_mode && tx_reload && !ph_q ##1 !ph_q;
    endsequence
    sequence s_quiet_irq;
        !ph_q ##1 (irq && !ph_q) ##1 !ph_q;
    endsequence

    // ============
    // Assertions
    // ============
    AST_RESET_CLEAR: assert property ($fell(sys_rst) |->
        !irq && !ir_enable && !rx_mode && modulator_time == 16'h0000)
        else $error("state not clear after reset");
    AST_RESERVED_ZERO: assert property (s_rd_ctl |=>
        s_rd_done ##0 (hrdata[31:4] == 28'h000_0000))
        else $error("reserved control bits not zero");
    AST_IRQ_HOLD: assert property (s_quiet_irq |=> irq)
        else $error("interrupt dropped without software clear");
    AST_IRQ_ON: assert property (s_reload |=> irq)
        else $error("reload did not raise interrupt");
    AST_IRQ_OFF: assert property (
        !$past(en_q) && $past(mask_q) == 2'h0 |-> !irq)
        else $error("interrupt while disabled");
    AST_TX_MT_STABLE: assert property (
        !$past(rx_mode) && !$past(wr_mt) && !$past(burst_rise)
        |-> $stable(modulator_time))
        else $error("modulator time moved in transmit mode");
    AST_BURST_LOAD: assert property (
        burst_rise |=> modulator_time == `IRTCB_BURST_LOAD)
        else $error("burst enable did not load one");
    AST_BURST_STEP: assert property (
        burst_q && $past(burst_q) && !$past(wr_mt)
        && !$stable(modulator_time)
        |-> modulator_time == $past(modulator_time) + 16'h0001)
        else $error("burst count moved by other than one");
endmodule

bind irtcb_top irtcb_checker u_chk (.clk_sys, .sys_rst, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hrdata, .tx_reload,
    .ir_enable, .rx_mode, .modulator_time, .irq);
`default_nettype wire

// File: dv/irtcb_ir_model.sv
`timescale 1ns/1ps
`default_nettype none

// ============
// Receive line and transmit reload source
// ============
module irtcb_ir_model (
    // Clock
    input wire logic clk_sys,
    // Lines into the block
    output logic ir_rx_pin,
    output logic tx_reload
);
    // Line idles low, no reload until asked
    initial begin
        ir_rx_pin = 1'b0;
        tx_reload = 1'b0;
    end
    // One-cycle reload pulse
    task automatic reload();
        tx_reload <= 1'b1;
        @(posedge clk_sys);
        tx_reload <= 1'b0;
    endtask
    // Flip the line, then hold it for gap cycles
    task automatic flip(input int gap);
        ir_rx_pin <= ~ir_rx_pin;
        repeat (gap) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// File: dv/irtcb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "irtcb_consts.svh"

// ============
// Self-checking bench
// ============
module irtcb_top_tb;
    localparam logic [31:0] z = 32'h0000_0000,
        a_car = {22'h0, `IRTCB_IDX_CARRIER, 2'h0},
        a_mt = {22'h0, `IRTCB_IDX_MOD_TIME, 2'h0},
        a_ctl = {22'h0, `IRTCB_IDX_CONTROL_B, 2'h0},
        a_tmr = {22'h0, `IRTCB_IDX_TIMER, 2'h0},
        a_cfg = {22'h0, `IRTCB_IDX_CONFIG, 2'h0},
        a_sts = {22'h0, `IRTCB_IDX_IRQ_STATUS, 2'h0},
        a_msk = {22'h0, `IRTCB_IDX_IRQ_MASK, 2'h0};
    logic clk_sys, sys_rst, hsel, hwrite;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, rdat, hrdata;
    logic hreadyout, hresp, ir_enable, rx_mode, irq, ir_rx_pin, tx_reload;
    logic [15:0] modulator_time, carrier_setting;
    wire hready;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    always #2 clk_sys = ~clk_sys;

    irtcb_top dut (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .ir_rx_pin,
        .tx_reload, .ir_enable, .rx_mode, .modulator_time, .carrier_setting,
        .irq);
    irtcb_ir_model u_ir (.clk_sys, .ir_rx_pin, .tx_reload);

    // Verdict and end of run
    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Compare one word
    task automatic chk(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // One transfer, paced by hready alone
    task automatic bus(input logic w, input logic [31:0] a, d);
        haddr <= a;
        hwrite <= w;
        htrans <= `IRTCB_HTRANS_NONSEQ;
        do @(posedge clk_sys); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Interrupt level after the one-cycle registering delay settles
    task automatic chk_irq(input logic exp);
        tick(3);
        chk(32'(irq), 32'(exp), "irq");
    endtask

    // Reset values, address alias, flag writes, reserved bits
    task automatic t_reset();
        bus(0, a_ctl, z);
        chk(rdat, z, "control reset");
        bus(0, a_mt, z);
        chk(rdat, z, "mod time reset");
        bus(1, 32'h0000_0414, 32'hFFFF_FFFF);
        bus(0, a_car, z);
        chk(rdat, z, "unmapped write");
        bus(1, a_ctl, 32'hFFFF_FFFF);
        bus(0, a_ctl, z);
        chk(rdat, 32'h0000_000C, "control readback");
        bus(0, a_mt, z);
        chk(rdat, 32'h0000_0001, "burst load");
        bus(1, a_ctl, z);
    endtask
    // Overflow flag, enable gating, hold, status and mask path
    task automatic t_overflow();
        logic [31:0] t0;
        bus(1, a_cfg, 32'h0000_0001);
        bus(1, a_tmr, 32'h0000_FFF0);
        tick(30);
        bus(0, a_ctl, z);
        chk(rdat, 32'h0000_0001, "overflow flag");
        chk_irq(1'b0);
        bus(1, a_cfg, z);
        bus(0, a_tmr, z);
        t0 = rdat;
        tick(5);
        bus(0, a_tmr, z);
        chk(rdat, t0, "timer hold");
        bus(1, a_ctl, 32'h0000_0005);
        chk_irq(1'b1);
        bus(1, a_ctl, 32'h0000_0004);
        chk_irq(1'b0);
        bus(1, a_msk, 32'h0000_0001);
        chk_irq(1'b1);
        bus(0, a_sts, z);
        chk(rdat, 32'h0000_0001, "status");
        chk_irq(1'b0);
        bus(1, a_msk, z);
        bus(1, a_ctl, z);
    endtask
    // Reload sets the event; edges with the burst bit set leave modulator time alone while transmitting
    task automatic t_tx();
        bus(1, a_cfg, 32'h0000_000D);
        bus(1, a_ctl, 32'h0000_000C);
        bus(1, a_mt, 32'h0000_1234);
        u_ir.reload();
        chk_irq(1'b1);
        u_ir.flip(8);
        bus(0, a_ctl, z);
        chk(rdat, 32'h0000_000E, "tx event");
        bus(0, a_mt, z);
        chk(rdat, 32'h0000_1234, "tx mod time");
        bus(1, a_ctl, 32'h0000_000C);
        chk_irq(1'b0);
        bus(1, a_ctl, z);
    endtask
    // Falling edge ignored with rising selected, then a real capture
    task automatic t_rx_cap();
        bus(1, a_cfg, 32'h0000_0007);
        bus(1, a_tmr, 32'h0000_0100);
        u_ir.flip(10);
        bus(0, a_mt, z);
        chk(rdat, 32'h0000_1234, "unselected edge");
        u_ir.flip(10);
        bus(0, a_mt, z);
        chk(32'(rdat[15:0] > 16'h0100 && rdat[15:0] < 16'h0140),
            32'h0000_0001, "capture value");
        bus(0, a_ctl, z);
        chk(rdat, 32'h0000_0002, "capture event");
        bus(1, a_ctl, z);
    endtask
    // Burst counting, then expiry of the doubled carrier interval
    task automatic t_burst();
        bus(1, a_car, 32'h0000_0014);
        bus(0, a_car, z);
        chk(rdat, 32'h0000_0014, "carrier");
        bus(1, a_cfg, 32'h0000_000F);
        chk({13'h0, hresp, ir_enable, rx_mode, carrier_setting},
            32'h0003_0014, "outputs");
        bus(1, a_ctl, 32'h0000_0008);
        repeat (3) u_ir.flip(6);
        bus(0, a_mt, z);
        chk(rdat, 32'h0000_0004, "burst count");
        tick(22);
        bus(0, a_ctl, z);
        chk(rdat, 32'h0000_0008, "interval early");
        tick(16);
        bus(0, a_ctl, z);
        chk(rdat, 32'h0000_000A, "interval expiry");
        bus(1, a_ctl, z);
        bus(1, a_cfg, z);
    endtask

    // Cycle ceiling so a hung handshake cannot stall the run
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end

    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        hsel = 1'b1;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = z;
        hwdata = z;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_overflow();
        t_tx();
        t_rx_cap();
        t_burst();
        finish_test();
    end
endmodule
`default_nettype wire

// File: logic/irtcb_consts.svh
`ifndef IRTCB_CONSTS_SVH
`define IRTCB_CONSTS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define IRTCB_IDX_CARRIER 8'h05
`define IRTCB_IDX_MOD_TIME 8'h06
`define IRTCB_IDX_CONTROL_B 8'h07
`define IRTCB_IDX_TIMER 8'h0C
`define IRTCB_IDX_CONFIG 8'h10
`define IRTCB_IDX_IRQ_STATUS 8'h11
`define IRTCB_IDX_IRQ_MASK 8'h12

// ==========================================================================
// Field positions of the control register B
// ==========================================================================
`define IRTCB_BIT_OVERFLOW 0
`define IRTCB_BIT_EVENT 1
`define IRTCB_BIT_IRQ_EN 2
`define IRTCB_BIT_BURST 3

// ==========================================================================
// Field positions of the configuration register
// ==========================================================================
`define IRTCB_BIT_IR_ENABLE 0
`define IRTCB_BIT_RX_MODE 1
`define IRTCB_BIT_EDGE_LO 2
`define IRTCB_BIT_EDGE_HI 3

// ==========================================================================
// Reset values, fixed loads and the NONSEQ transfer code
// ==========================================================================
`define IRTCB_RST_CONTROL_B 8'h00
`define IRTCB_RST_WORD16 16'h0000
`define IRTCB_RST_CONFIG 4'h0
`define IRTCB_RST_IRQ2 2'h0
`define IRTCB_BURST_LOAD 16'h0001
`define IRTCB_RST_RDATA 32'h0000_0000
`define IRTCB_HTRANS_NONSEQ 2'h2

`endif

// File: logic/irtcb_interval.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Retriggerable interval timer, expires after limit cycles
// ==========================================================================
module irtcb_interval #(
    parameter int CNT_W = 17
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Control
    input wire logic active,
    input wire logic restart,
    input wire logic [CNT_W-1:0] limit,
    // Expiry pulse
    output logic expire
);

    irtcb_pkg::irtcb_iv_state_t state_q;
    irtcb_pkg::irtcb_iv_state_t state_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic expire_q;
    logic expire_d;
    logic at_end;

    if (CNT_W < 2) begin : g_chk
        $error("irtcb_interval: CNT_W too small");
    end

    // Limit zero counts as a one-cycle interval
    assign at_end = (count_q + {{(CNT_W-1){1'b0}}, 1'b1}) >= limit;

    // Every restart while active reopens the window; expiry is one shot per burst
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        expire_d = 1'b0;
        case (state_q)
            irtcb_pkg::IRTCB_IV_IDLE: begin
                if (active && restart) begin
                    state_d = irtcb_pkg::IRTCB_IV_RUN;
                    count_d = '0;
                end
            end
            irtcb_pkg::IRTCB_IV_RUN: begin
                if (!active) begin
                    state_d = irtcb_pkg::IRTCB_IV_IDLE;
                end else if (restart) begin
                    count_d = '0;
                end else if (at_end) begin
                    state_d = irtcb_pkg::IRTCB_IV_IDLE;
                    expire_d = 1'b1;
                end else begin
                    count_d = count_q + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            default: begin
                state_d = irtcb_pkg::IRTCB_IV_IDLE;
                count_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= irtcb_pkg::IRTCB_IV_IDLE;
            count_q <= '0;
            expire_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            expire_q <= expire_d;
        end
    end

    assign expire = expire_q;

endmodule

`default_nettype wire

// File: logic/irtcb_pkg.sv
// ==========================================================================
// Types shared by the IR timer control block
// ==========================================================================
package irtcb_pkg;

    // Interval timer states, one-hot
    typedef enum logic [1:0] {
        IRTCB_IV_IDLE = 2'b01,
        IRTCB_IV_RUN = 2'b10
    } irtcb_iv_state_t;

endpackage

// File: logic/irtcb_sync.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Two-flop synchroniser for the receive pin
// ==========================================================================
module irtcb_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Pin side
    input wire logic async_in,
    // Synchronised level
    output logic sync_out
);

    logic meta_q;
    logic sync_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

`default_nettype wire

// File: logic/irtcb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "irtcb_consts.svh"

// Contract
// - Any reset clears control register B
// - Upper four control bits read zero
// - Overflow sets flag, cleared by writing zero
// - Transmit reload sets event flag
// - Receive capture sets event flag, burst off
// - Burst mode: 2x carrier interval sets event
// - Event flag holds until software writes zero
// - Enable one: either flag requests interrupt
// - Enable zero: no timer interrupt; the status and mask path still raises irq when a status bit and its mask bit are both set
// - Burst bit ignored in transmit mode; a rising write still loads modulator time one
// - Burst bit rising loads modulator time one
// - Burst mode: no capture into modulator time
// - Burst mode: modulator time counts edges
// - Burst off: normal capture on edges
// - Capture timer value on qualified edges
// - Timer counts while enabled, else holds
module irtcb_top #(
    parameter int TIMER_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Infrared side
    input wire logic ir_rx_pin,
    input wire logic tx_reload,
    // State to the modulator
    output logic ir_enable,
    output logic rx_mode,
    output logic [15:0] modulator_time,
    output logic [15:0] carrier_setting,
    // Interrupt
    output logic irq
);

    // ======================================================================
    // Elaboration checks
    // ======================================================================
    if (TIMER_W != 16) begin : g_chk
        $error("irtcb_top: only a 16-bit timer is supported");
    end

    // ======================================================================
    // Decoding
    // ======================================================================
    // Word index of a byte address; used for read and write decode
    function automatic logic [7:0] word_index(input logic [31:0] a);
        word_index = a[9:2];
    endfunction

    logic addr_ok_q;
    logic [7:0] widx_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic hreadyout_q;
    logic hresp_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic take;
    logic take_wr;
    logic take_rd;
    logic [7:0] widx_now;

    // Upper address bits must be zero for a register hit
    assign take = hsel && hready && (htrans == `IRTCB_HTRANS_NONSEQ);
    assign take_wr = take && hwrite;
    assign take_rd = take && !hwrite;
    assign widx_now = word_index(haddr);

    // Register state
    logic ovf_q;
    logic evt_q;
    logic irq_en_q;
    logic burst_q;
    logic [15:0] carrier_q;
    logic [15:0] mod_time_q;
    logic [15:0] timer_q;
    logic [3:0] config_q;
    logic [1:0] irq_status_q;
    logic [1:0] irq_mask_q;
    logic irq_q;

    // Write strobes and the status read strobe, applied in the data phase
    logic wr_ctl;
    logic wr_carrier;
    logic wr_mod;
    logic wr_timer;
    logic wr_config;
    logic wr_mask;
    logic rd_status;

    assign wr_ctl = wr_pend_q && addr_ok_q
        && (widx_q == `IRTCB_IDX_CONTROL_B);
    assign wr_carrier = wr_pend_q && addr_ok_q
        && (widx_q == `IRTCB_IDX_CARRIER);
    assign wr_mod = wr_pend_q && addr_ok_q
        && (widx_q == `IRTCB_IDX_MOD_TIME);
    assign wr_timer = wr_pend_q && addr_ok_q
        && (widx_q == `IRTCB_IDX_TIMER);
    assign wr_config = wr_pend_q && addr_ok_q
        && (widx_q == `IRTCB_IDX_CONFIG);
    assign wr_mask = wr_pend_q && addr_ok_q
        && (widx_q == `IRTCB_IDX_IRQ_MASK);
    assign rd_status = rd_pend_q && addr_ok_q
        && (widx_q == `IRTCB_IDX_IRQ_STATUS);

    // ======================================================================
    // Bus slave
    // ======================================================================
    // Reads take one wait state so a write just before is seen
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            addr_ok_q <= 1'b0;
            widx_q <= 8'h00;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= take_wr;
            rd_pend_q <= take_rd;
            if (take) begin
                addr_ok_q <= (haddr[31:10] == 22'h00_0000);
                widx_q <= widx_now;
            end
        end
    end

    // Read mux; unmapped words and reserved bits read zero
    assign rd_mux =
        !addr_ok_q ? `IRTCB_RST_RDATA :
        (widx_q == `IRTCB_IDX_CONTROL_B) ?
            {28'h000_0000, burst_q, irq_en_q, evt_q, ovf_q} :
        (widx_q == `IRTCB_IDX_CARRIER) ? {16'h0000, carrier_q} :
        (widx_q == `IRTCB_IDX_MOD_TIME) ? {16'h0000, mod_time_q} :
        (widx_q == `IRTCB_IDX_TIMER) ? {16'h0000, timer_q} :
        (widx_q == `IRTCB_IDX_CONFIG) ? {28'h000_0000, config_q} :
        (widx_q == `IRTCB_IDX_IRQ_STATUS) ?
            {30'h0000_0000, irq_status_q} :
        (widx_q == `IRTCB_IDX_IRQ_MASK) ?
            {30'h0000_0000, irq_mask_q} :
        `IRTCB_RST_RDATA;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            hrdata_q <= `IRTCB_RST_RDATA;
        end else begin
            hresp_q <= 1'b0;
            hreadyout_q <= !take_rd;
            if (rd_pend_q) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // ======================================================================
    // Receive pin and edge select
    // ======================================================================
    logic rx_sync;
    logic rx_prev_q;
    logic rx_rise;
    logic rx_fall;
    logic rx_edge;
    logic [1:0] edge_sel;
    logic rx_active;
    logic burst_active;
    logic capture;
    logic burst_step;

    irtcb_sync u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in(ir_rx_pin),
        .sync_out(rx_sync)
    );

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rx_prev_q <= 1'b0;
        end else begin
            rx_prev_q <= rx_sync;
        end
    end

    // Edge select: 01 rising, 10 falling, 11 both, 00 none
    assign edge_sel = config_q[`IRTCB_BIT_EDGE_HI:`IRTCB_BIT_EDGE_LO];
    assign rx_rise = rx_sync && !rx_prev_q;
    assign rx_fall = !rx_sync && rx_prev_q;
    assign rx_edge = (edge_sel[0] && rx_rise) || (edge_sel[1] && rx_fall);
    assign rx_active = config_q[`IRTCB_BIT_IR_ENABLE]
        && config_q[`IRTCB_BIT_RX_MODE];
    assign burst_active = rx_active && burst_q;
    assign capture = rx_active && !burst_q && rx_edge;
    assign burst_step = burst_active && rx_edge;

    // ======================================================================
    // Burst interval timer
    // ======================================================================
    logic interval_expire;
    logic [16:0] interval_limit;

    assign interval_limit = {carrier_q, 1'b0};

    irtcb_interval #(
        .CNT_W(17)
    ) u_interval (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .active(burst_active),
        .restart(burst_step),
        .limit(interval_limit),
        .expire(interval_expire)
    );

    // ======================================================================
    // IR timer value
    // ======================================================================
    logic timer_wrap;
    logic tx_event;
    logic [15:0] timer_d;

    // Wraps from all ones; a software write takes priority over counting
    assign timer_wrap = config_q[`IRTCB_BIT_IR_ENABLE]
        && (timer_q == 16'hFFFF);
    assign tx_event = config_q[`IRTCB_BIT_IR_ENABLE]
        && !config_q[`IRTCB_BIT_RX_MODE] && tx_reload;
    assign timer_d =
        wr_timer ? hwdata[15:0] :
        tx_event ? `IRTCB_RST_WORD16 :
        config_q[`IRTCB_BIT_IR_ENABLE] ? timer_q + 16'h0001 :
        timer_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            timer_q <= `IRTCB_RST_WORD16;
        end else begin
            timer_q <= timer_d;
        end
    end

    // ======================================================================
    // Control register B
    // ======================================================================
    logic ovf_d;
    logic evt_d;
    logic evt_set;
    logic burst_rise;

    // Hardware set wins over a software clear in the same cycle
    assign evt_set = tx_event
        || capture
        || (burst_active && interval_expire);
    assign ovf_d = timer_wrap
        || (ovf_q && !(wr_ctl && !hwdata[`IRTCB_BIT_OVERFLOW]));
    assign evt_d = evt_set
        || (evt_q && !(wr_ctl && !hwdata[`IRTCB_BIT_EVENT]));
    assign burst_rise = wr_ctl && !burst_q && hwdata[`IRTCB_BIT_BURST];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_q <= 1'b0;
            evt_q <= 1'b0;
            irq_en_q <= 1'b0;
            burst_q <= 1'b0;
        end else begin
            ovf_q <= ovf_d;
            evt_q <= evt_d;
            if (wr_ctl) begin
                irq_en_q <= hwdata[`IRTCB_BIT_IRQ_EN];
                burst_q <= hwdata[`IRTCB_BIT_BURST];
            end
        end
    end

    // ======================================================================
    // Modulator time, carrier and configuration
    // ======================================================================
    logic [15:0] mod_time_d;

    // Software write first, then burst arming, then edge activity
    assign mod_time_d =
        wr_mod ? hwdata[15:0] :
        burst_rise ? `IRTCB_BURST_LOAD :
        burst_step ? mod_time_q + 16'h0001 :
        capture ? timer_q :
        mod_time_q;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mod_time_q <= `IRTCB_RST_WORD16;
            carrier_q <= `IRTCB_RST_WORD16;
            config_q <= `IRTCB_RST_CONFIG;
        end else begin
            mod_time_q <= mod_time_d;
            if (wr_carrier) begin
                carrier_q <= hwdata[15:0];
            end
            if (wr_config) begin
                config_q <= hwdata[3:0];
            end
        end
    end

    // ======================================================================
    // Interrupt status, mask and request
    // ======================================================================
    logic [1:0] irq_events;
    logic [1:0] irq_status_d;
    logic irq_d;

    // Status bit 0 overflow, bit 1 event; a read clears, a set wins
    assign irq_events = {evt_set, timer_wrap};
    assign irq_status_d = irq_events
        | (rd_status ? 2'b00 : irq_status_q);
    // Mask defaults to zero so only the control enable path acts
    assign irq_d = (irq_en_q && (ovf_q || evt_q))
        || |(irq_status_q & irq_mask_q);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status_q <= `IRTCB_RST_IRQ2;
            irq_mask_q <= `IRTCB_RST_IRQ2;
            irq_q <= 1'b0;
        end else begin
            irq_status_q <= irq_status_d;
            irq_q <= irq_d;
            if (wr_mask) begin
                irq_mask_q <= hwdata[1:0];
            end
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;
    assign ir_enable = config_q[`IRTCB_BIT_IR_ENABLE];
    assign rx_mode = config_q[`IRTCB_BIT_RX_MODE];
    assign modulator_time = mod_time_q;
    assign carrier_setting = carrier_q;
    assign irq = irq_q;

endmodule

`default_nettype wire
